// *** hdl/debug_reset_pin_mux.sv ***
// debug and reset pad multiplexer with apb register access
// assumes apb on pclk, slow rc clock tick arrives synchronous to pclk
`include "pin_mux_cfg.svh"

module debug_reset_pin_mux #(
	parameter int unsigned FORCE_TICKS = `LRC_TICKS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic low_speed_rc_oscillator,
	input wire logic dbg_clk_pad_in,
	input wire logic dbg_dat_pad_in,
	input wire logic dbg_dat_drive,
	input wire logic dbg_dat_out,
	input wire logic external_reset_pad_in,
	input wire logic port_two_bit_thirteen_out,
	input wire logic port_two_bit_thirteen_oe,
	input wire logic port_two_bit_zero_out,
	input wire logic port_two_bit_zero_oe,
	input wire logic port_zero_bit_two_out,
	input wire logic port_zero_bit_two_oe,
	output logic dbg_clk_pad_out,
	output logic dbg_clk_pad_oe,
	output logic dbg_clk_pad_pullup,
	output logic dbg_dat_pad_out,
	output logic dbg_dat_pad_oe,
	output logic dbg_dat_pad_pullup,
	output logic reset_pad_out,
	output logic reset_pad_oe,
	output logic port_two_bit_thirteen_in,
	output logic port_two_bit_zero_in,
	output logic port_zero_bit_two_in,
	output logic dbg_swclk,
	output logic dbg_swdio_in,
	output logic dbg_access_en,
	output logic ext_reset_req,
	output logic cpu_run
);

	logic [31:0] rst_cfg_q;
	logic [31:0] pullup_q;
	logic [31:0] status_d;
	logic [31:0] rdata_d;
	logic lrc_q;
	logic lrc_tick;
	logic [$clog2(FORCE_TICKS+1)-1:0] tick_cnt_q;
	pin_mux_pkg::window_state_t win_q;
	logic dbg_gpio;
	logic rst_gpio;
	logic wr_en;
	logic acc;

	assign acc = psel && penable;
	assign wr_en = acc && pwrite;

	// ------------------------------------------------------------
	// forced debug window after power-on
	// ------------------------------------------------------------
	// edge of the slow clock, taken as synchronous to pclk
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// reset high: a slow clock already high at release must not count as a tick
			lrc_q <= 1'b1;
		end else begin
			lrc_q <= low_speed_rc_oscillator;
		end
	end
	assign lrc_tick = low_speed_rc_oscillator && !lrc_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_q <= '0;
			win_q <= pin_mux_pkg::WIN_HOLD;
		end else if (win_q == pin_mux_pkg::WIN_HOLD && lrc_tick) begin
			if (tick_cnt_q == FORCE_TICKS[$bits(tick_cnt_q)-1:0] - 1'b1) begin
				win_q <= pin_mux_pkg::WIN_OPEN;
			end
			tick_cnt_q <= tick_cnt_q + 1'b1;
		end
	end

	// enables kept in register; debug enable gated only by the window, reset enable not gated
	assign dbg_gpio = rst_cfg_q[`RST_CFG_GPIO_DBG_BIT] && (win_q == pin_mux_pkg::WIN_OPEN);
	assign rst_gpio = rst_cfg_q[`RST_CFG_GPIO_RST_BIT];

	// ------------------------------------------------------------
	// apb registers
	// ------------------------------------------------------------
	// reset value keeps debug function
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_cfg_q <= `RST_CFG_RESET;
			pullup_q <= `PULLUP_RESET;
		end else if (wr_en) begin
			if (paddr == `RST_CFG_ADDR) begin
				rst_cfg_q <= pwdata & ((32'h1 << `RST_CFG_GPIO_DBG_BIT) | (32'h1 << `RST_CFG_GPIO_RST_BIT));
			end
			if (paddr == `PULLUP_ADDR) begin
				pullup_q <= pwdata & ((32'h1 << `PULLUP_CLK_BIT) | (32'h1 << `PULLUP_DAT_BIT));
			end
		end
	end

	always_comb begin
		status_d = '0;
		status_d[`ST_WINDOW_BIT] = (win_q == pin_mux_pkg::WIN_HOLD);
		status_d[`ST_DBG_GPIO_BIT] = dbg_gpio;
		status_d[`ST_RST_GPIO_BIT] = rst_gpio;
		status_d[`ST_PAD_LVL_BIT] = external_reset_pad_in;
		status_d[`ST_CPU_RUN_BIT] = cpu_run;
	end

	always_comb begin
		case (paddr)
			`RST_CFG_ADDR: rdata_d = rst_cfg_q;
			`PULLUP_ADDR: rdata_d = pullup_q;
			`STATUS_ADDR: rdata_d = status_d;
			default: rdata_d = '0;
		endcase
	end

	// zero-wait slave: pready rises in the setup cycle's following edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			prdata <= (psel && !penable && !pwrite) ? rdata_d : '0;
			pslverr <= psel && !penable && paddr != `RST_CFG_ADDR && paddr != `PULLUP_ADDR
				&& paddr != `STATUS_ADDR;
		end
	end

	// ------------------------------------------------------------
	// pad multiplexing
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dbg_clk_pad_out <= 1'b0;
			dbg_clk_pad_oe <= 1'b0;
			dbg_clk_pad_pullup <= 1'b1;
			dbg_dat_pad_out <= 1'b0;
			dbg_dat_pad_oe <= 1'b0;
			dbg_dat_pad_pullup <= 1'b1;
			port_two_bit_thirteen_in <= 1'b0;
			port_two_bit_zero_in <= 1'b0;
			dbg_swclk <= 1'b0;
			dbg_swdio_in <= 1'b1;
			dbg_access_en <= 1'b1;
		end else if (dbg_gpio) begin
			// pads become port two bits 13 and 0
			dbg_clk_pad_out <= port_two_bit_thirteen_out;
			dbg_clk_pad_oe <= port_two_bit_thirteen_oe;
			dbg_dat_pad_out <= port_two_bit_zero_out;
			dbg_dat_pad_oe <= port_two_bit_zero_oe;
			port_two_bit_thirteen_in <= dbg_clk_pad_in;
			port_two_bit_zero_in <= dbg_dat_pad_in;
			dbg_clk_pad_pullup <= pullup_q[`PULLUP_CLK_BIT];
			dbg_dat_pad_pullup <= pullup_q[`PULLUP_DAT_BIT];
			dbg_swclk <= 1'b0;
			dbg_swdio_in <= 1'b1;
			dbg_access_en <= 1'b0;
		end else begin
			// clock pad never driven; data pad driven only on turnaround
			dbg_clk_pad_out <= 1'b0;
			dbg_clk_pad_oe <= 1'b0;
			dbg_dat_pad_out <= dbg_dat_out;
			dbg_dat_pad_oe <= dbg_dat_drive;
			dbg_clk_pad_pullup <= 1'b1;
			dbg_dat_pad_pullup <= 1'b1;
			port_two_bit_thirteen_in <= 1'b0;
			port_two_bit_zero_in <= 1'b0;
			dbg_swclk <= dbg_clk_pad_in;
			dbg_swdio_in <= dbg_dat_pad_in;
			// reset pad setting has no say here
			dbg_access_en <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reset_pad_out <= 1'b0;
			reset_pad_oe <= 1'b0;
			port_zero_bit_two_in <= 1'b0;
			ext_reset_req <= 1'b0;
			cpu_run <= 1'b0;
		end else if (rst_gpio) begin
			// pad is plain gpio, no reset source
			reset_pad_out <= port_zero_bit_two_out;
			reset_pad_oe <= port_zero_bit_two_oe;
			port_zero_bit_two_in <= external_reset_pad_in;
			ext_reset_req <= 1'b0;
			cpu_run <= 1'b1;
		end else begin
			reset_pad_out <= 1'b0;
			reset_pad_oe <= 1'b0;
			port_zero_bit_two_in <= 1'b0;
			ext_reset_req <= !external_reset_pad_in;
			cpu_run <= external_reset_pad_in;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	clk_input_only_a: assert property (@(posedge pclk) disable iff (!presetn)
		!dbg_gpio |=> !dbg_clk_pad_oe)
		else $error("debug clock pad driven in debug function");

	pad_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
		dbg_gpio && $stable(dbg_gpio) |=> dbg_clk_pad_oe == $past(port_two_bit_thirteen_oe))
		else $error("clock pad not following port two bit 13");

	cfg_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		!rst_cfg_q[`RST_CFG_GPIO_DBG_BIT] |=> dbg_access_en)
		else $error("debug access lost without enable");

	pullup_forced_a: assert property (@(posedge pclk) disable iff (!presetn)
		!dbg_gpio |=> dbg_clk_pad_pullup && dbg_dat_pad_pullup)
		else $error("pull-up off in debug function");

	window_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		win_q == pin_mux_pkg::WIN_HOLD |=> dbg_access_en)
		else $error("gpio took over during forced window");

	gpio_blocks_a: assert property (@(posedge pclk) disable iff (!presetn)
		dbg_gpio |=> !dbg_access_en && !dbg_swclk)
		else $error("debug reachable while pads are gpio");

	reset_default_a: assert property (@(posedge pclk) disable iff (!presetn)
		!rst_gpio && !external_reset_pad_in |=> ext_reset_req && !cpu_run)
		else $error("reset pad low did not hold reset");

	reset_ignored_a: assert property (@(posedge pclk) disable iff (!presetn)
		rst_gpio |=> !ext_reset_req)
		else $error("gpio reset pad still resets");

	late_enable_a: assert property (@(posedge pclk) disable iff (!presetn)
		rst_cfg_q[`RST_CFG_GPIO_DBG_BIT] && $rose(win_q == pin_mux_pkg::WIN_OPEN) |=> !dbg_access_en)
		else $error("retained enable not applied after window");

	dat_turn_a: assert property (@(posedge pclk) disable iff (!presetn)
		!dbg_gpio |=> dbg_dat_pad_oe == $past(dbg_dat_drive))
		else $error("data pad drive not following debug turnaround");

	dat_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
		dbg_gpio |=> dbg_dat_pad_oe == $past(port_two_bit_zero_oe) && port_two_bit_zero_in == $past(dbg_dat_pad_in))
		else $error("data pad not following port two bit 0");

	gpio_pullup_a: assert property (@(posedge pclk) disable iff (!presetn)
		dbg_gpio |=> dbg_clk_pad_pullup == $past(pullup_q[`PULLUP_CLK_BIT])
			&& dbg_dat_pad_pullup == $past(pullup_q[`PULLUP_DAT_BIT]))
		else $error("gpio pull-up not taken from enable bits");

	window_count_a: assert property (@(posedge pclk) disable iff (!presetn)
		win_q == pin_mux_pkg::WIN_OPEN |-> tick_cnt_q == FORCE_TICKS[$bits(tick_cnt_q)-1:0])
		else $error("forced window ended before its tick count");

	reset_gpio_a: assert property (@(posedge pclk) disable iff (!presetn)
		rst_gpio |=> port_zero_bit_two_in == $past(external_reset_pad_in) && reset_pad_oe == $past(port_zero_bit_two_oe))
		else $error("reset pad not acting as gpio");

	reset_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
		!rst_gpio && external_reset_pad_in |=> cpu_run && !ext_reset_req)
		else $error("execution held after reset pad release");

	debug_kept_a: assert property (@(posedge pclk) disable iff (!presetn)
		rst_gpio && !dbg_gpio |=> dbg_access_en)
		else $error("reset pad gpio blocked debug access");

	cfg_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && pwrite && paddr == `RST_CFG_ADDR |=> rst_cfg_q[`RST_CFG_GPIO_DBG_BIT]
			== $past(pwdata[`RST_CFG_GPIO_DBG_BIT]))
		else $error("debug reassignment enable not written");

	ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("pready held beyond one cycle");

endmodule // debug_reset_pin_mux

// *** hdl/pin_mux_cfg.svh ***
// pin mux constants: register offsets, field positions, reset values, timing
// assumes inclusion by bare name from the design file
`ifndef PIN_MUX_CFG_SVH
`define PIN_MUX_CFG_SVH

`define RST_CFG_ADDR 12'h000
`define PULLUP_ADDR 12'h004
`define STATUS_ADDR 12'h008
`define RST_CFG_GPIO_RST_BIT 5
`define RST_CFG_GPIO_DBG_BIT 6
`define PULLUP_CLK_BIT 13
`define PULLUP_DAT_BIT 0
`define RST_CFG_RESET 32'h0000_0000
`define PULLUP_RESET 32'h0000_0000
`define ST_WINDOW_BIT 0
`define ST_DBG_GPIO_BIT 1
`define ST_RST_GPIO_BIT 2
`define ST_PAD_LVL_BIT 3
`define ST_CPU_RUN_BIT 4
`define FORCE_DBG_MS 30
`define LRC_HZ 64000
`define LRC_TICKS ((`FORCE_DBG_MS * `LRC_HZ + 999) / 1000)

`endif

// *** hdl/pin_mux_pkg.sv ***
// pin mux types shared by the design
// assumes the cfg header holds all numeric constants
package pin_mux_pkg;
	typedef enum logic [1:0] {
		WIN_HOLD = 2'b00,
		WIN_OPEN = 2'b01
	} window_state_t;
endpackage

// *** test/debug_reset_pin_mux_bench.sv ***
// self-checking bench for the debug and reset pad multiplexer
// assumes the probe model on the pads and apb with zero wait states
module debug_reset_pin_mux_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] lc = 4'h0;
	logic [5:0] gp = 6'h00;
	logic pready, pslverr, er, ddrv = 1'b0, dout = 1'b0, cval = 1'b0, rlow = 1'b0;
	logic cpad, dpad, rpad, c_out, c_oe, c_pu, d_out, d_oe, d_pu, r_out, r_oe;
	logic p13, p0, p02, swclk, swdio, acc, xreq, run;
	int bad_count = 0, checks_done = 0, cyc = 0, n;
	// rows: cfg6 cfg5 pull13 clk_level reset_low | access swclk p13 pullup run p02
	logic [10:0] rows [8] = '{11'b00010_110110, 11'b00101_100100, 11'b10010_001010,
		11'b10100_000110, 11'b01011_110110, 11'b11111_001110, 11'b01000_100111, 11'b00010_110110};
	// -------------------------------
	// clocks and model
	// -------------------------------
	always #20 pclk = ~pclk;
	always @(posedge pclk) begin
		lc <= lc + 4'h1;
		cyc <= presetn ? cyc + 1 : 0;
	end
	debug_reset_pin_mux #(.FORCE_TICKS(4)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .low_speed_rc_oscillator(lc[3]), .dbg_clk_pad_in(cpad),
		.dbg_dat_pad_in(dpad), .dbg_dat_drive(ddrv), .dbg_dat_out(dout), .external_reset_pad_in(rpad),
		.port_two_bit_thirteen_out(gp[0]), .port_two_bit_thirteen_oe(gp[1]), .port_two_bit_zero_out(gp[2]),
		.port_two_bit_zero_oe(gp[3]), .port_zero_bit_two_out(gp[4]), .port_zero_bit_two_oe(gp[5]),
		.dbg_clk_pad_out(c_out), .dbg_clk_pad_oe(c_oe), .dbg_clk_pad_pullup(c_pu), .dbg_dat_pad_out(d_out),
		.dbg_dat_pad_oe(d_oe), .dbg_dat_pad_pullup(d_pu), .reset_pad_out(r_out), .reset_pad_oe(r_oe),
		.port_two_bit_thirteen_in(p13), .port_two_bit_zero_in(p0), .port_zero_bit_two_in(p02),
		.dbg_swclk(swclk), .dbg_swdio_in(swdio), .dbg_access_en(acc), .ext_reset_req(xreq), .cpu_run(run));
	swd_probe_model i_probe (.pclk(pclk), .clk_drive(1'b1), .clk_val(cval), .dat_drive(1'b1),
		.dat_val(1'b1), .rst_low(rlow), .clk_oe(c_oe), .clk_out(c_out), .clk_pu(c_pu), .dat_oe(d_oe),
		.dat_out(d_out), .dat_pu(d_pu), .rst_oe(r_oe), .rst_out(r_out), .clk_pad(cpad), .dat_pad(dpad),
		.rst_pad(rpad));
	// -------------------------------
	// tasks
	// -------------------------------
	task automatic end_of_test();
		if (bad_count == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", nm, exp, got);
			bad_count++;
		end
	endtask
	// request held until pready is seen at a rising edge; data taken at that same edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && k < 20) begin
			@(posedge pclk);
			k++;
		end
		if (k >= 20) begin
			$display("Error pready expected 1 seen 0");
			bad_count++;
			end_of_test();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	initial begin
		repeat (5000) @(posedge pclk);
		bad_count++;
		end_of_test();
	end
	// -------------------------------
	// sequence
	// -------------------------------
	initial begin
		repeat (11) @(posedge pclk);
		@(negedge pclk);
		chk("reset pullup", 32'h1, 32'(c_pu));
		chk("reset access", 32'h1, 32'(acc));
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h008, 32'h0);
		chk("window flag", 32'h1, rd & 32'h1);
		apb(1'b1, 12'h000, 32'h60);
		@(negedge pclk);
		chk("access in window", 32'h1, 32'(acc));
		n = 0;
		while (acc === 1'b1 && n < 300) begin
			@(negedge pclk);
			n++;
		end
		chk("window length", 32'h1, 32'(cyc >= 48 && n < 300));
		apb(1'b0, 12'h008, 32'h0);
		chk("status after window", 32'h1E, rd);
		apb(1'b0, 12'h000, 32'h0);
		chk("config readback", 32'h60, rd);
		apb(1'b1, 12'h004, 32'hFFFFFFFF);
		apb(1'b0, 12'h004, 32'h0);
		chk("pullup readback", 32'h2001, rd);
		apb(1'b0, 12'h00C, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, er});
		chk("unmapped data", 32'h0, rd);
		// reassignment rows only after the forced window has run out
		foreach (rows[i]) begin
			apb(1'b1, 12'h000, {25'h0, rows[i][10:9], 5'h0});
			apb(1'b1, 12'h004, {18'h0, rows[i][8], 13'h0});
			cval <= rows[i][7];
			rlow <= rows[i][6];
			repeat (3) @(negedge pclk);
			chk("row outputs", {26'h0, rows[i][5:0]}, {26'h0, acc, swclk, p13, c_pu, run, p02});
			chk("reset request", 32'(!rows[i][9] & rows[i][6]), 32'(xreq));
		end
		@(posedge pclk);
		gp <= 6'h3F;
		ddrv <= 1'b1;
		repeat (3) @(negedge pclk);
		chk("clock pad drive", 32'h0, 32'(c_oe));
		chk("data turnaround", 32'h2, {30'h0, d_oe, d_out});
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(negedge pclk);
		chk("second reset", 32'h3, {30'h0, c_pu, acc});
		@(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(negedge pclk);
		chk("release access", 32'h1, 32'(acc));
		apb(1'b0, 12'h000, 32'h0);
		chk("config after reset", 32'h0, rd);
		apb(1'b0, 12'h008, 32'h0);
		chk("window restarts", 32'h1, rd & 32'h1);
		end_of_test();
	end
endmodule // debug_reset_pin_mux_bench

// *** test/swd_probe_model.sv ***
// external debug probe and board reset circuit seen at the three pads
// assumes pad enables from the mux are high while the mux drives
module swd_probe_model (
	input wire logic pclk,
	input wire logic clk_drive,
	input wire logic clk_val,
	input wire logic dat_drive,
	input wire logic dat_val,
	input wire logic rst_low,
	input wire logic clk_oe,
	input wire logic clk_out,
	input wire logic clk_pu,
	input wire logic dat_oe,
	input wire logic dat_out,
	input wire logic dat_pu,
	input wire logic rst_oe,
	input wire logic rst_out,
	output logic clk_pad,
	output logic dat_pad,
	output logic rst_pad
);
	timeunit 1ns;
	timeprecision 1ps;
	logic flip_q = 1'b0;
	// -------------------------------
	// pad resolution
	// -------------------------------
	// an undriven pad without pull-up keeps changing, so a stale level never passes
	always_ff @(posedge pclk) begin
		flip_q <= !flip_q;
	end
	// probe drives clock and data when clk_drive and dat_drive are set, unless the mux drives the pad
	assign clk_pad = clk_oe ? clk_out : clk_drive ? clk_val : clk_pu | flip_q;
	assign dat_pad = dat_oe ? dat_out : dat_drive ? dat_val : dat_pu | flip_q;
	// board circuit pulls low; pad pull-up otherwise
	assign rst_pad = rst_oe ? rst_out : !rst_low;
endmodule // swd_probe_model
